// [gpioev_params.svh]
`ifndef GPIOEV_PARAMS_SVH
`define GPIOEV_PARAMS_SVH
// Pin configuration bit positions
`define GPIOEV_CFG_OE 0
`define GPIOEV_CFG_PP 1
`define GPIOEV_CFG_PU 2
`define GPIOEV_CFG_LOCK 3
`define GPIOEV_CFG_LEVEL 4
`define GPIOEV_CFG_POL 5
`define GPIOEV_CFG_DEB 6
// Routing bit positions
`define GPIOEV_RT_IRQ 0
`define GPIOEV_RT_SMI 1
`define GPIOEV_RT_PWU 2
// Reset values
`define GPIOEV_CFG_RST 8'h0044
`define GPIOEV_RT_RST 8'h0001
`define GPIOEV_BYTE_RST 8'h0000
// Locked configuration bits 0..3
`define GPIOEV_LOCK_MASK 8'h000F
// Runtime register selects
`define GPIOEV_SEL_OUT 2'h0
`define GPIOEV_SEL_IN 2'h1
`define GPIOEV_SEL_EN 2'h2
`define GPIOEV_SEL_ST 2'h3
// Clock edges after reset before pin edges count
`define GPIOEV_SYNC_WARM 3'h5
`endif

// [gpioev_pkg.sv]
package gpioev_pkg;
	typedef logic [7:0] gpioev_byte_t;
	typedef logic [1:0] gpioev_sel_t;
endpackage

// [gpioev_cfg_mem.sv]
`timescale 1ns/1ns
`include "gpioev_params.svh"
// Per-pin configuration and routing bytes with registered read data
module gpioev_cfg_mem #(
	parameter int NPINS = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Write port
	input wire logic wr_en,
	input wire logic wr_route,
	input wire logic [2:0] wr_pin,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [2:0] rd_pin,
	input wire logic rd_route,
	output logic [7:0] rd_data,
	// Flattened contents
	output logic [NPINS*8-1:0] cfg_flat,
	output logic [NPINS*8-1:0] route_flat
);
	logic [7:0] cfg_ff [NPINS];
	logic [7:0] route_ff [NPINS];
	logic [7:0] rd_data_ff;
	logic [7:0] wr_mask;
	logic locked;

	assign locked = cfg_ff[wr_pin][`GPIOEV_CFG_LOCK];
	// Lock freezes bits 0-3 and can only be set
	assign wr_mask = locked ? ~8'(`GPIOEV_LOCK_MASK) : 8'h00FF; // RQ6 RQ7
	assign rd_data = rd_data_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < NPINS; i++) begin
				cfg_ff[i] <= `GPIOEV_CFG_RST;
				route_ff[i] <= `GPIOEV_RT_RST;
			end
			rd_data_ff <= `GPIOEV_BYTE_RST;
		end else begin
			if (wr_en && !wr_route)
				cfg_ff[wr_pin] <= ((cfg_ff[wr_pin] & ~wr_mask) | (wr_data & wr_mask)) & 8'h007F; // RQ2
			if (wr_en && wr_route)
				route_ff[wr_pin] <= wr_data & 8'h0007;
			rd_data_ff <= rd_route ? route_ff[rd_pin] : cfg_ff[rd_pin];
		end
	end

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			cfg_flat[i*8 +: 8] = cfg_ff[i];
			route_flat[i*8 +: 8] = route_ff[i];
		end
	end

	if (NPINS < 1 || NPINS > 8) begin : g_npins_bad
		$error("NPINS must be 1..8");
	end
endmodule // gpioev_cfg_mem

// [gpioev_port.sv]
// What this block does
// RQ1: Eight pins, four byte runtime registers
// RQ2: Ten configuration bits per pin, two bytes; the block keeps seven bits (0-6) in one byte
// RQ3: Output enable bit 0 sets direction
// RQ4: Bit 1 chooses push-pull or open-drain
// RQ5: Bit 2 enables weak pull-up always
// RQ6: Lock blocks latch and config bits 0-3
// RQ7: Lock cleared only by hardware reset
// RQ8: Latch driven to pin when enabled
// RQ9: Latch read returns stored value
// RQ10: Input read returns present pin levels
// RQ11: Writes to input register are discarded
// RQ12: External input activates the port
// RQ13: Inactive port blocks data access, inputs
// RQ14: Deactivation keeps config and latch
// RQ15: Bit 4 selects edge or level
// RQ16: Bit 5 selects falling/low or rising/high
// RQ17: Detect active edge or active level
// RQ18: Every pin can raise notification
// RQ19: Edge status set by hardware, W1C
// RQ20: Pending needs enable plus level or status
// RQ21: Routed outputs assert while any pending
// RQ22: Inactive port blocks all notification
// RQ23: Pin inputs synchronised before use
`timescale 1ns/1ns
`include "gpioev_params.svh"
module gpioev_port #(
	parameter int NPINS = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Activation from device configuration
	input wire logic port_active, // RQ12
	// Runtime register access
	input wire logic rt_wr,
	input wire logic rt_rd,
	input wire gpioev_pkg::gpioev_sel_t rt_sel,
	input wire gpioev_pkg::gpioev_byte_t rt_wdata,
	output gpioev_pkg::gpioev_byte_t rt_rdata,
	// Configuration access
	input wire logic cfg_wr,
	input wire logic cfg_route,
	input wire logic [2:0] cfg_pin,
	input wire gpioev_pkg::gpioev_byte_t cfg_wdata,
	output gpioev_pkg::gpioev_byte_t cfg_rdata,
	// Pins
	input wire logic [NPINS-1:0] port_pin_n_in,
	output logic [NPINS-1:0] port_pin_n_out,
	output logic [NPINS-1:0] port_pin_n_oe,
	output logic [NPINS-1:0] port_pin_n_pullup,
	// Notification
	output logic irq_request,
	output logic system_management_interrupt,
	output logic power_up_request
);
	logic [NPINS*8-1:0] cfg_flat;
	logic [NPINS*8-1:0] route_flat;
	logic [NPINS-1:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
	logic [NPINS-1:0] output_latch_reg_ff, nxt_output_latch;
	logic [NPINS-1:0] event_enable_reg_ff, nxt_event_enable;
	logic [NPINS-1:0] edge_status_reg_ff, nxt_edge_status;
	logic [NPINS-1:0] oe_bits, pp_bits, lock_bits, lvl_bits, pol_bits;
	logic [NPINS-1:0] irq_bits, smi_bits, pwu_bits;
	logic [NPINS-1:0] pin_prev_ff, pin_view, active_level, active_edge, pending;
	logic [NPINS-1:0] wr_bits;
	logic [7:0] rdata_ff, nxt_rdata;
	logic wr_out, wr_en_reg, wr_st;
	logic [2:0] warm_ff, nxt_warm;
	logic warm_done;

	function automatic logic [NPINS-1:0] cfg_col(input logic [NPINS*8-1:0] flat, input int pos);
		logic [NPINS-1:0] r;
		r = '0;
		for (int i = 0; i < NPINS; i++)
			r[i] = flat[i*8 + pos];
		return r;
	endfunction

	gpioev_cfg_mem #(
		.NPINS(NPINS)
	) i_gpioev_cfg_mem (
		.ref_clk(ref_clk),
		.reset(reset),
		.wr_en(cfg_wr),
		.wr_route(cfg_route),
		.wr_pin(cfg_pin),
		.wr_data(cfg_wdata),
		.rd_pin(cfg_pin),
		.rd_route(cfg_route),
		.rd_data(cfg_rdata),
		.cfg_flat(cfg_flat),
		.route_flat(route_flat)
	);

	assign oe_bits = cfg_col(cfg_flat, `GPIOEV_CFG_OE);
	assign pp_bits = cfg_col(cfg_flat, `GPIOEV_CFG_PP);
	assign lock_bits = cfg_col(cfg_flat, `GPIOEV_CFG_LOCK);
	assign lvl_bits = cfg_col(cfg_flat, `GPIOEV_CFG_LEVEL);
	assign pol_bits = cfg_col(cfg_flat, `GPIOEV_CFG_POL);
	assign irq_bits = cfg_col(route_flat, `GPIOEV_RT_IRQ);
	assign smi_bits = cfg_col(route_flat, `GPIOEV_RT_SMI);
	assign pwu_bits = cfg_col(route_flat, `GPIOEV_RT_PWU);

	// Open-drain drives only the low level; config and latch untouched when inactive
	assign port_pin_n_out = output_latch_reg_ff; // RQ8 RQ14
	assign port_pin_n_oe = oe_bits & (pp_bits | ~output_latch_reg_ff); // RQ3 RQ4
	assign port_pin_n_pullup = cfg_col(cfg_flat, `GPIOEV_CFG_PU); // RQ5

	// Accepted pin change once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
			pin_ff <= '0;
		end else begin
			sync1_ff <= port_pin_n_in; // RQ23
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			pin_ff <= (sync2_ff == sync3_ff) ? sync3_ff : pin_ff;
		end
	end

	// Inputs blocked while inactive
	assign pin_view = port_active ? pin_ff : '0; // RQ13
	assign active_level = ~(pin_view ^ pol_bits); // RQ16
	assign active_edge = (pin_view ^ pin_prev_ff) & active_level & {NPINS{warm_done}}; // RQ17

	// Edges count only once the synchroniser has caught up after reset
	assign warm_done = warm_ff == `GPIOEV_SYNC_WARM;
	assign nxt_warm = warm_done ? warm_ff : warm_ff + 3'h1;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			warm_ff <= '0;
		end else begin
			warm_ff <= nxt_warm;
		end
	end

	assign wr_bits = rt_wdata[NPINS-1:0];
	assign wr_out = rt_wr && port_active && rt_sel == `GPIOEV_SEL_OUT; // RQ13
	assign wr_en_reg = rt_wr && port_active && rt_sel == `GPIOEV_SEL_EN;
	assign wr_st = rt_wr && port_active && rt_sel == `GPIOEV_SEL_ST;
	// Locked pins keep their latch bit
	assign nxt_output_latch = wr_out ?
		((output_latch_reg_ff & lock_bits) | (wr_bits & ~lock_bits)) :
		output_latch_reg_ff; // RQ6 RQ11
	assign nxt_event_enable = wr_en_reg ? wr_bits : event_enable_reg_ff;
	// Set wins over write-one-clear; cleared while inactive
	assign nxt_edge_status = !port_active ? '0 :
		((edge_status_reg_ff & ~(wr_st ? wr_bits : '0)) | active_edge); // RQ19

	// Pending per pin, then routed
	assign pending = event_enable_reg_ff &
		((lvl_bits & active_level) | (~lvl_bits & edge_status_reg_ff)); // RQ15 RQ20 RQ18
	assign irq_request = port_active && |(pending & irq_bits); // RQ21 RQ22
	assign system_management_interrupt = port_active && |(pending & smi_bits); // RQ21 RQ22
	assign power_up_request = port_active && |(pending & pwu_bits); // RQ21 RQ22

	always_comb begin
		nxt_rdata = '0;
		if (rt_rd && port_active) begin
			case (rt_sel)
				`GPIOEV_SEL_OUT: nxt_rdata[NPINS-1:0] = output_latch_reg_ff; // RQ9
				`GPIOEV_SEL_IN: nxt_rdata[NPINS-1:0] = pin_view; // RQ10
				`GPIOEV_SEL_EN: nxt_rdata[NPINS-1:0] = event_enable_reg_ff;
				`GPIOEV_SEL_ST: nxt_rdata[NPINS-1:0] = edge_status_reg_ff;
				default: nxt_rdata = '0;
			endcase
		end
	end
	assign rt_rdata = rdata_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			output_latch_reg_ff <= '0;
			event_enable_reg_ff <= '0;
			edge_status_reg_ff <= '0;
			pin_prev_ff <= '0;
			rdata_ff <= `GPIOEV_BYTE_RST;
		end else begin
			output_latch_reg_ff <= nxt_output_latch; // RQ1
			event_enable_reg_ff <= nxt_event_enable;
			edge_status_reg_ff <= nxt_edge_status;
			pin_prev_ff <= pin_ff;
			rdata_ff <= nxt_rdata;
		end
	end

	if (NPINS < 1 || NPINS > 8) begin : g_npins_bad
		$error("NPINS must be 1..8");
	end

	// Lock, latch, input and enable registers
	chk_lock_latch: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
		(lock_bits[0] && wr_out) |=> $stable(output_latch_reg_ff[0]))
		else $error("locked latch bit changed");
	chk_lock_all_bits: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
		wr_out |=> (((output_latch_reg_ff ^ $past(output_latch_reg_ff)) & $past(lock_bits)) == '0))
		else $error("locked latch bits changed");
	chk_lock_sticky: assert property (@(posedge ref_clk) disable iff (reset) // RQ7
		lock_bits[0] |=> lock_bits[0])
		else $error("lock bit cleared");
	chk_lock_all_sticky: assert property (@(posedge ref_clk) disable iff (reset) // RQ7
		(($past(lock_bits) & ~lock_bits) == '0))
		else $error("a lock bit cleared");
	chk_latch_write: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
		(wr_out && lock_bits == '0) |=> output_latch_reg_ff == $past(wr_bits))
		else $error("latch write lost");
	chk_input_ignored: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
		(rt_wr && rt_sel == `GPIOEV_SEL_IN) |=>
		$stable(output_latch_reg_ff) && $stable(event_enable_reg_ff))
		else $error("input register write had effect");
	chk_en_write: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
		wr_en_reg |=> event_enable_reg_ff == $past(wr_bits))
		else $error("event enable write lost");

	// Pin drive
	chk_drive_dir: assert property (@(posedge ref_clk) disable iff (reset) // RQ3
		!oe_bits[0] |-> !port_pin_n_oe[0])
		else $error("pin driven while disabled");
	chk_pp_drive: assert property (@(posedge ref_clk) disable iff (reset) // RQ4 RQ8
		((oe_bits & pp_bits & ~port_pin_n_oe) == '0))
		else $error("push-pull pin not driven");
	chk_od_high: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
		((port_pin_n_oe & ~pp_bits & port_pin_n_out) == '0))
		else $error("open-drain pin driven high");

	// Reads and activation
	chk_latch_read: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
		(rt_rd && port_active && rt_sel == `GPIOEV_SEL_OUT) |=>
		rt_rdata[NPINS-1:0] == $past(output_latch_reg_ff))
		else $error("latch readback wrong");
	chk_input_read: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
		(rt_rd && port_active && rt_sel == `GPIOEV_SEL_IN) |=>
		rt_rdata[NPINS-1:0] == $past(pin_ff))
		else $error("pin readback wrong");
	chk_enable_read: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
		(rt_rd && port_active && rt_sel == `GPIOEV_SEL_EN) |=>
		rt_rdata[NPINS-1:0] == $past(event_enable_reg_ff))
		else $error("enable readback wrong");
	chk_status_read: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
		(rt_rd && port_active && rt_sel == `GPIOEV_SEL_ST) |=>
		rt_rdata[NPINS-1:0] == $past(edge_status_reg_ff))
		else $error("status readback wrong");
	chk_inactive_read: assert property (@(posedge ref_clk) disable iff (reset) // RQ13
		(rt_rd && !port_active) |=> rt_rdata == '0)
		else $error("read served while inactive");
	chk_inactive_keep: assert property (@(posedge ref_clk) disable iff (reset) // RQ13 RQ14
		(!port_active && rt_wr) |=> $stable(output_latch_reg_ff))
		else $error("latch written while inactive");
	chk_inactive_enable: assert property (@(posedge ref_clk) disable iff (reset) // RQ13
		(!port_active && rt_wr) |=> $stable(event_enable_reg_ff))
		else $error("enable written while inactive");
	chk_deact_keep: assert property (@(posedge ref_clk) disable iff (reset) // RQ14
		($fell(port_active) && !cfg_wr) |=> $stable(cfg_flat) && $stable(output_latch_reg_ff))
		else $error("deactivation changed pin setup");
	chk_inactive_clear: assert property (@(posedge ref_clk) disable iff (reset) // RQ22
		!port_active |=> edge_status_reg_ff == '0)
		else $error("status kept while inactive");

	// Event detection
	chk_sync_agree: assert property (@(posedge ref_clk) disable iff (reset) // RQ23
		$changed(pin_ff) |-> ($past(sync2_ff) == $past(sync3_ff)))
		else $error("pin accepted before stages agreed");
	chk_edge_sets: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
		(port_active && active_edge[0]) |=> edge_status_reg_ff[0])
		else $error("edge status not set");
	chk_status_set: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
		port_active |=> (($past(active_edge) & ~edge_status_reg_ff) == '0))
		else $error("an edge status not set");
	chk_w1c_clears: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
		(wr_st && wr_bits[0] && !active_edge[0]) |=> !edge_status_reg_ff[0])
		else $error("edge status not cleared");
	chk_status_w0: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
		(wr_st && !wr_bits[1] && edge_status_reg_ff[1]) |=> edge_status_reg_ff[1])
		else $error("zero write cleared status");
	chk_rise_edge: assert property (@(posedge ref_clk) disable iff (reset) // RQ16 RQ17
		(warm_done && port_active && pol_bits[1] && $rose(pin_ff[1])) |=> edge_status_reg_ff[1])
		else $error("rising edge missed");
	chk_fall_edge: assert property (@(posedge ref_clk) disable iff (reset) // RQ16 RQ17
		(warm_done && port_active && !pol_bits[2] && $fell(pin_ff[2])) |=> edge_status_reg_ff[2])
		else $error("falling edge missed");
	chk_level_high: assert property (@(posedge ref_clk) disable iff (reset) // RQ15 RQ16
		(port_active && event_enable_reg_ff[1] && lvl_bits[1] && pol_bits[1] && pin_ff[1]) |->
		pending[1])
		else $error("high level not pending");

	// Notification
	chk_inactive_quiet: assert property (@(posedge ref_clk) disable iff (reset) // RQ22
		!port_active |-> !irq_request && !system_management_interrupt && !power_up_request)
		else $error("notification while inactive");
	chk_irq_route: assert property (@(posedge ref_clk) disable iff (reset) // RQ21
		(port_active && pending[0] && irq_bits[0]) |-> irq_request)
		else $error("irq missing");
	chk_level_irq: assert property (@(posedge ref_clk) disable iff (reset) // RQ15 RQ20
		(port_active && |(event_enable_reg_ff & lvl_bits & ~(pin_ff ^ pol_bits) & irq_bits)) |->
		irq_request)
		else $error("level event not notified");
	chk_edge_smi: assert property (@(posedge ref_clk) disable iff (reset) // RQ20 RQ21
		(port_active && |(event_enable_reg_ff & ~lvl_bits & edge_status_reg_ff & smi_bits)) |->
		system_management_interrupt)
		else $error("edge event not notified");
	chk_pwu_route: assert property (@(posedge ref_clk) disable iff (reset) // RQ18 RQ21
		(port_active && |(pending & pwu_bits)) |-> power_up_request)
		else $error("power-up request missing");
	chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (reset) // RQ21
		!(|(pending & irq_bits)) |-> !irq_request)
		else $error("irq without pending pin");
	chk_smi_quiet: assert property (@(posedge ref_clk) disable iff (reset) // RQ21
		!(|(pending & smi_bits)) |-> !system_management_interrupt)
		else $error("management interrupt without pending pin");
	chk_pwu_quiet: assert property (@(posedge ref_clk) disable iff (reset) // RQ21
		!(|(pending & pwu_bits)) |-> !power_up_request)
		else $error("power-up request without pending pin");
endmodule // gpioev_port

// [gpioev_pin_model.sv]
`timescale 1ns/1ns
// Far side of the pins: an external driver, the weak pull-up or a floating line
module gpioev_pin_model (
	// Clock
	input wire logic ref_clk,
	// Port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] oe,
	input wire logic [7:0] pull_en,
	// External driver
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// Resolved wire
	output logic [7:0] pin_level
);
	logic float_ff = 1'b0;
	// A floating line never holds its last value
	always_ff @(posedge ref_clk) begin
		float_ff <= ~float_ff;
	end
	assign pin_level = (oe & pin_out)
		| (~oe & ext_en & ext_val)
		| (~oe & ~ext_en & pull_en)
		| (~oe & ~ext_en & ~pull_en & {8{float_ff}});
endmodule // gpioev_pin_model

// [gpioev_port_tb_top.sv]
`timescale 1ns/1ns
module gpioev_port_tb_top;
	logic ref_clk = 0, reset = 1, port_active = 1, rt_wr = 0, rt_rd = 0;
	logic cfg_wr = 0, cfg_route = 0, rd_d = 0;
	logic irq_request, system_management_interrupt, power_up_request;
	gpioev_pkg::gpioev_sel_t rt_sel = '0;
	gpioev_pkg::gpioev_byte_t rt_wdata = '0, rt_rdata, cfg_wdata = '0, cfg_rdata, eb;
	logic [2:0] cfg_pin = '0;
	logic [7:0] port_pin_n_in, port_pin_n_out, port_pin_n_oe, port_pin_n_pullup;
	logic [7:0] ext_en = 8'hFF, ext_val = 8'h00, lat;
	int mismatches = 0, comparisons = 0, seed = 46451;
	gpioev_pkg::gpioev_byte_t expq[$];
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
	always #20 ref_clk = ~ref_clk;
	gpioev_port #(.NPINS(8)) i_gpioev_port (.ref_clk, .reset, .port_active,
		.rt_wr, .rt_rd, .rt_sel, .rt_wdata, .rt_rdata,
		.cfg_wr, .cfg_route, .cfg_pin, .cfg_wdata, .cfg_rdata,
		.port_pin_n_in, .port_pin_n_out, .port_pin_n_oe, .port_pin_n_pullup,
		.irq_request, .system_management_interrupt, .power_up_request);
	gpioev_pin_model i_gpioev_pin_model (.ref_clk, .pin_out(port_pin_n_out),
		.oe(port_pin_n_oe), .pull_en(port_pin_n_pullup), .ext_en, .ext_val,
		.pin_level(port_pin_n_in));
	// Read data stands in the cycle after the read strobe edge
	always @(posedge ref_clk) begin
		if (rd_d) begin
			eb = expq.pop_front();
			`CHK(rt_rdata, eb)
		end
		rd_d <= rt_rd;
	end
	task automatic rt_acc(input logic w, input gpioev_pkg::gpioev_sel_t s,
		input gpioev_pkg::gpioev_byte_t d);
		@(negedge ref_clk);
		rt_wr = w;
		rt_rd = ~w;
		rt_sel = s;
		rt_wdata = d;
		@(negedge ref_clk);
		rt_wr = 0;
		rt_rd = 0;
	endtask
	task automatic rd(input gpioev_pkg::gpioev_sel_t s, input gpioev_pkg::gpioev_byte_t e);
		expq.push_back(e);
		rt_acc(0, s, 8'h00);
	endtask
	task automatic cfg(input logic [2:0] p, input logic r, input gpioev_pkg::gpioev_byte_t d);
		@(negedge ref_clk);
		cfg_wr = 1;
		cfg_pin = p;
		cfg_route = r;
		cfg_wdata = d;
		@(negedge ref_clk);
		cfg_wr = 0;
	endtask
	task automatic cfg_chk(input logic [2:0] p, input logic r, input gpioev_pkg::gpioev_byte_t e);
		@(negedge ref_clk);
		cfg_pin = p;
		cfg_route = r;
		repeat (2) @(negedge ref_clk);
		`CHK(cfg_rdata, e)
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#(40 * 3000);
		mismatches++;
		conclude();
	end
	initial begin
		repeat (8) @(negedge ref_clk);
		reset = 0;
		cfg_chk(3'h0, 0, 8'h44);
		cfg_chk(3'h0, 1, 8'h01);
		for (int i = 0; i < 8; i++) cfg(i[2:0], 0, 8'h07);
		lat = $random(seed);
		rt_acc(1, 2'h0, lat);
		rt_acc(1, 2'h1, ~lat);
		repeat (6) @(negedge ref_clk);
		`CHK(port_pin_n_out, lat)
		`CHK(port_pin_n_oe, 8'hFF)
		rd(2'h0, lat);
		rd(2'h1, lat);
		cfg(3'h7, 0, 8'h01);
		@(negedge ref_clk);
		`CHK({port_pin_n_oe[7], port_pin_n_pullup[7]}, {~lat[7], 1'b0})
		cfg(3'h0, 0, 8'h0F);
		cfg(3'h0, 0, 8'h00);
		cfg_chk(3'h0, 0, 8'h0F);
		rt_acc(1, 2'h0, ~lat);
		rd(2'h0, {~lat[7:1], lat[0]});
		port_active = 0;
		rd(2'h0, 8'h00);
		rt_acc(1, 2'h0, lat);
		`CHK(port_pin_n_out, {~lat[7:1], lat[0]})
		port_active = 1;
		rd(2'h0, {~lat[7:1], lat[0]});
		cfg(3'h1, 0, 8'h24);
		cfg(3'h1, 1, 8'h07);
		cfg(3'h2, 0, 8'h14);
		repeat (8) @(negedge ref_clk);
		rt_acc(1, 2'h3, 8'hFF);
		rd(2'h3, 8'h00);
		rt_acc(1, 2'h2, 8'h02);
		ext_val = 8'h02;
		repeat (8) @(negedge ref_clk);
		rd(2'h3, 8'h02);
		`CHK({irq_request, system_management_interrupt, power_up_request}, 3'b111)
		rt_acc(1, 2'h3, 8'h00);
		rd(2'h3, 8'h02);
		rt_acc(1, 2'h3, 8'h02);
		rd(2'h3, 8'h00);
		`CHK({irq_request, system_management_interrupt, power_up_request}, 3'b000)
		ext_val = 8'h00;
		repeat (8) @(negedge ref_clk);
		rd(2'h3, 8'h00);
		rt_acc(1, 2'h2, 8'h04);
		@(negedge ref_clk);
		`CHK({irq_request, system_management_interrupt, power_up_request}, 3'b100)
		port_active = 0;
		@(negedge ref_clk);
		`CHK({irq_request, system_management_interrupt, power_up_request}, 3'b000)
		port_active = 1;
		repeat (3) @(negedge ref_clk);
		conclude();
	end
endmodule // gpioev_port_tb_top
